// ===== src/gpb_params.svh
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH

`define GPB_DATA_REGION   2'h0
`define GPB_OFS_DIR       12'h400
`define GPB_OFS_SENSE     12'h404
`define GPB_OFS_BOTH      12'h408
`define GPB_OFS_POLARITY  12'h40c
`define GPB_OFS_MASK      12'h410
`define GPB_OFS_RAW       12'h414
`define GPB_OFS_MASKED    12'h418
`define GPB_OFS_CLEAR     12'h41c
`define GPB_OFS_ALTSEL    12'h420
`define GPB_OFS_OPENDRAIN 12'h50c
`define GPB_OFS_PULLUP    12'h510
`define GPB_OFS_PULLDOWN  12'h514
`define GPB_OFS_DIGEN     12'h51c
`define GPB_OFS_LOCK      12'h520
`define GPB_OFS_COMMIT    12'h524
`define GPB_OFS_IDENT     12'hfe0

`define GPB_PRESENT_PINS  8'hff
`define GPB_PROTECT_PINS  8'h80
`define GPB_TRIGGER_PIN   4
`define GPB_LOCK_KEY      32'h5a5ac3c3
`define GPB_IDENT_VALUE   32'h00000c10
`define GPB_LOCKED_READ   32'h00000001

`endif

// ===== src/gpb_pkg.sv
package gpb_pkg;

    typedef logic [7:0] gpb_pins_t;

    typedef struct packed {
        gpb_pins_t   sync1;
        gpb_pins_t   sync2;
        gpb_pins_t   sync3;
        gpb_pins_t   stable;
        gpb_pins_t   prev_din;
        gpb_pins_t   data;
        gpb_pins_t   dir;
        gpb_pins_t   sense;
        gpb_pins_t   both;
        gpb_pins_t   polarity;
        gpb_pins_t   mask;
        gpb_pins_t   edge_lat;
        gpb_pins_t   altsel;
        gpb_pins_t   open_drain_select;
        gpb_pins_t   pur;
        gpb_pins_t   pdr;
        gpb_pins_t   den;
        gpb_pins_t   commit;
        logic        unlocked;
        gpb_pins_t   pin_out;
        gpb_pins_t   pin_oe_n;
        gpb_pins_t   alt_in;
        logic        irq;
        logic        trig;
        logic [31:0] rdata;
    } gpb_state_s;

endpackage : gpb_pkg

// ===== src/gpb_port.sv
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "gpb_params.svh"

module gpb_port (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Register port.
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Pads.
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_n,
    output logic      [7:0]  pad_pull_up,
    output logic      [7:0]  pad_pull_down,
    output logic      [7:0]  pad_digital_en,
    // Peripheral hand-over.
    input  wire logic [7:0]  alt_out,
    input  wire logic [7:0]  alt_drive,
    output logic      [7:0]  alt_in,
    // Events.
    output logic             irq,
    output logic             conv_trigger
);

    localparam gpb_pkg::gpb_state_s RESET_STATE = '{
        sync1:    8'h00,
        sync2:    8'h00,
        sync3:    8'h00,
        stable:   8'h00,
        prev_din: 8'h00,
        data:     8'h00,
        dir:      8'h00,
        sense:    8'h00,
        both:     8'h00,
        polarity: 8'h00,
        mask:     8'h00,
        edge_lat: 8'h00,
        altsel:   `GPB_PROTECT_PINS,
        open_drain_select:      8'h00,
        pur:      `GPB_PROTECT_PINS,
        pdr:      8'h00,
        den:      `GPB_PROTECT_PINS,
        commit:   `GPB_PRESENT_PINS & ~`GPB_PROTECT_PINS,
        unlocked: 1'b0,
        pin_out:  8'h00,
        pin_oe_n: 8'hff,
        alt_in:   8'h00,
        irq:      1'b0,
        trig:     1'b0,
        rdata:    32'h0
    };

    gpb_pkg::gpb_state_s st;
    gpb_pkg::gpb_state_s next_st;

    logic [7:0] din;
    logic [7:0] edge_set;
    logic [7:0] level_hit;
    logic [7:0] raw;
    logic [7:0] masked;
    logic [7:0] clr_mask;
    logic [7:0] alt_writable;
    logic       data_hit;

    // Edge hit of one pin from its configuration and two consecutive samples.
    function automatic logic edge_hit(input logic both, input logic pol,
                                      input logic prev, input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        edge_hit = both ? (rise | fall) : (pol ? rise : fall);
    endfunction : edge_hit

    // Stores an eight-bit field, keeping unconnected pins at zero.
    function automatic logic [7:0] pin_field(input logic [31:0] value);
        pin_field = value[7:0] & `GPB_PRESENT_PINS;
    endfunction : pin_field

    always_comb begin
        logic val;
        logic drv;
        val = 1'b0;
        drv = 1'b0;
        next_st = st;
        din = st.stable & st.den;
        data_hit = (addr[11:10] == `GPB_DATA_REGION);
        clr_mask = 8'h00;
        alt_writable = ~`GPB_PROTECT_PINS | (st.commit & {8{st.unlocked}});
        for (int i = 0; i < 8; i++) begin
            edge_set[i] = ~st.sense[i] &
                          edge_hit(st.both[i], st.polarity[i], st.prev_din[i], din[i]);
            level_hit[i] = st.sense[i] & ~(st.polarity[i] ^ din[i]);
        end
        raw = (st.edge_lat | level_hit) & `GPB_PRESENT_PINS;
        masked = raw & st.mask;

        // Three stage synchroniser, a change counts once stages two and three agree.
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < 8; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.stable[i] = st.sync3[i];
            end
        end
        next_st.prev_din = din;

        next_st.rdata = 32'h0;
        if (wr) begin
            if (data_hit) begin
                next_st.data = (st.data & ~addr[9:2]) | (pin_field(wdata) & addr[9:2]);
            end else begin
                case (addr)
                    `GPB_OFS_DIR:       next_st.dir = pin_field(wdata);
                    `GPB_OFS_SENSE:     next_st.sense = pin_field(wdata);
                    `GPB_OFS_BOTH:      next_st.both = pin_field(wdata);
                    `GPB_OFS_POLARITY:  next_st.polarity = pin_field(wdata);
                    `GPB_OFS_MASK:      next_st.mask = pin_field(wdata);
                    `GPB_OFS_CLEAR:     clr_mask = pin_field(wdata);
                    `GPB_OFS_ALTSEL: begin
                        next_st.altsel = (pin_field(wdata) & alt_writable) |
                                         (st.altsel & ~alt_writable);
                    end
                    `GPB_OFS_OPENDRAIN: next_st.open_drain_select = pin_field(wdata);
                    `GPB_OFS_PULLUP:    next_st.pur = pin_field(wdata);
                    `GPB_OFS_PULLDOWN:  next_st.pdr = pin_field(wdata);
                    `GPB_OFS_DIGEN:     next_st.den = pin_field(wdata);
                    `GPB_OFS_LOCK:      next_st.unlocked = (wdata == `GPB_LOCK_KEY);
                    `GPB_OFS_COMMIT: begin
                        // Only protected pins are committable; the others stay read-only.
                        if (st.unlocked) begin
                            next_st.commit = (pin_field(wdata) & `GPB_PROTECT_PINS) |
                                             (st.commit & ~`GPB_PROTECT_PINS);
                        end
                    end
                    default: ;
                endcase
            end
        end

        if (rd) begin
            if (data_hit) begin
                next_st.rdata = {24'h0, ((st.dir & st.data) | (~st.dir & din)) &
                                 addr[9:2] & `GPB_PRESENT_PINS};
            end else begin
                case (addr)
                    `GPB_OFS_DIR:       next_st.rdata = {24'h0, st.dir};
                    `GPB_OFS_SENSE:     next_st.rdata = {24'h0, st.sense};
                    `GPB_OFS_BOTH:      next_st.rdata = {24'h0, st.both};
                    `GPB_OFS_POLARITY:  next_st.rdata = {24'h0, st.polarity};
                    `GPB_OFS_MASK:      next_st.rdata = {24'h0, st.mask};
                    `GPB_OFS_RAW:       next_st.rdata = {24'h0, raw};
                    `GPB_OFS_MASKED:    next_st.rdata = {24'h0, masked};
                    `GPB_OFS_ALTSEL:    next_st.rdata = {24'h0, st.altsel};
                    `GPB_OFS_OPENDRAIN: next_st.rdata = {24'h0, st.open_drain_select};
                    `GPB_OFS_PULLUP:    next_st.rdata = {24'h0, st.pur};
                    `GPB_OFS_PULLDOWN:  next_st.rdata = {24'h0, st.pdr};
                    `GPB_OFS_DIGEN:     next_st.rdata = {24'h0, st.den};
                    `GPB_OFS_LOCK:      next_st.rdata = st.unlocked ? 32'h0 : `GPB_LOCKED_READ;
                    `GPB_OFS_COMMIT:    next_st.rdata = {24'h0, st.commit};
                    `GPB_OFS_IDENT:     next_st.rdata = `GPB_IDENT_VALUE;
                    default:            next_st.rdata = 32'h0;
                endcase
            end
        end

        // A new edge in the clearing cycle wins, so no event is lost.
        next_st.edge_lat = ((st.edge_lat & ~clr_mask) | edge_set) & `GPB_PRESENT_PINS;

        // Reprogramming sense bits changes raw at once, so unmasked pins can fire.
        next_st.irq = |masked;
        next_st.trig = masked[`GPB_TRIGGER_PIN];

        // Pad drive: open-drain only ever pulls low, nothing drives without digital-enable.
        for (int i = 0; i < 8; i++) begin
            val = st.altsel[i] ? alt_out[i] : st.data[i];
            drv = st.altsel[i] ? alt_drive[i] : st.dir[i];
            next_st.pin_out[i] = st.open_drain_select[i] ? 1'b0 : val;
            next_st.pin_oe_n[i] = ~(st.den[i] & drv & (~st.open_drain_select[i] | ~val));
        end
        next_st.alt_in = din & st.altsel;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign pin_out = st.pin_out;
    assign pin_oe_n = st.pin_oe_n;
    assign pad_pull_up = st.pur;
    assign pad_pull_down = st.pdr;
    assign pad_digital_en = st.den;
    assign alt_in = st.alt_in;
    assign irq = st.irq;
    assign conv_trigger = st.trig;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_data_write;
        wr && (addr[11:10] == `GPB_DATA_REGION);
    endsequence

    sequence s_data_read;
        rd && (addr[11:10] == `GPB_DATA_REGION);
    endsequence

    property p_masked_write;
        s_data_write |=> ((st.data ^ $past(st.data)) & ~$past(addr[9:2])) == 8'h00;
    endproperty
    a_masked_write: assert property (p_masked_write)
        else $error("Unmasked data bit changed.");

    property p_write_value;
        s_data_write |=> ((st.data ^ $past(wdata[7:0])) & $past(addr[9:2])) == 8'h00;
    endproperty
    a_write_value: assert property (p_write_value)
        else $error("Masked data bit not written.");

    property p_masked_read;
        s_data_read |=> (rdata & ~{24'h0, $past(addr[9:2])}) == 32'h0;
    endproperty
    a_masked_read: assert property (p_masked_read)
        else $error("Masked-out read bit not zero.");

    property p_irq_merge;
        ##1 irq == $past(|(raw & st.mask));
    endproperty
    a_irq_merge: assert property (p_irq_merge) else $error("Interrupt output mismatch.");

    property p_edge_hold;
        ##1 ($past(st.edge_lat) & ~$past(clr_mask) & ~st.edge_lat) == 8'h00;
    endproperty
    a_edge_hold: assert property (p_edge_hold) else $error("Edge latch dropped uncleared.");

    property p_clear;
        (wr && addr == `GPB_OFS_CLEAR && edge_set == 8'h00)
            |=> (st.edge_lat & $past(wdata[7:0])) == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not remove latch.");

    property p_raw_read;
        (rd && addr == `GPB_OFS_RAW) |=> rdata == {24'h0, $past(raw)};
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("Raw status read mismatch.");

    property p_trigger;
        ##1 conv_trigger == $past(raw[`GPB_TRIGGER_PIN] & st.mask[`GPB_TRIGGER_PIN]);
    endproperty
    a_trigger: assert property (p_trigger) else $error("Converter trigger mismatch.");

    property p_commit;
        (wr && addr == `GPB_OFS_ALTSEL && !st.unlocked)
            |=> ((st.altsel ^ $past(st.altsel)) & `GPB_PROTECT_PINS) == 8'h00;
    endproperty
    a_commit: assert property (p_commit)
        else $error("Protected select changed while locked.");

    property p_drive_needs_den;
        ##1 (~pin_oe_n & ~$past(st.den)) == 8'h00;
    endproperty
    a_drive_needs_den: assert property (p_drive_needs_den)
        else $error("Pin driven without enable.");

    sequence s_locked_commit_write;
        wr && (addr == `GPB_OFS_COMMIT) && !st.unlocked;
    endsequence

    property p_commit_locked;
        s_locked_commit_write |=> $stable(st.commit);
    endproperty
    a_commit_locked: assert property (p_commit_locked)
        else $error("Commit bits changed while locked.");

    property p_masked_status;
        (rd && addr == `GPB_OFS_MASKED) |=> rdata == {24'h0, $past(raw & st.mask)};
    endproperty
    a_masked_status: assert property (p_masked_status)
        else $error("Masked status read mismatch.");

    // Detection is restated from the configuration bits, so a broken helper cannot hide.
    property p_rise_latch;
        ##1 (~$past(st.sense) & ~$past(st.both) & $past(st.polarity) &
             ~$past(st.prev_din) & $past(din) & ~st.edge_lat) == 8'h00;
    endproperty
    a_rise_latch: assert property (p_rise_latch)
        else $error("Rising edge not latched.");

    property p_fall_latch;
        ##1 (~$past(st.sense) & ~$past(st.both) & ~$past(st.polarity) &
             $past(st.prev_din) & ~$past(din) & ~st.edge_lat) == 8'h00;
    endproperty
    a_fall_latch: assert property (p_fall_latch)
        else $error("Falling edge not latched.");

    property p_level_no_latch;
        ##1 ($past(st.sense) & ~$past(st.edge_lat) & st.edge_lat) == 8'h00;
    endproperty
    a_level_no_latch: assert property (p_level_no_latch)
        else $error("Level pin set an edge latch.");

    property p_level_follow;
        ((raw ^ (st.polarity ~^ din)) & st.sense & ~st.edge_lat) == 8'h00;
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("Level condition does not follow the pin.");

    property p_sync_agree;
        ##1 ((st.stable ^ $past(st.stable)) & ($past(st.sync2) ^ $past(st.sync3))) == 8'h00;
    endproperty
    a_sync_agree: assert property (p_sync_agree)
        else $error("Input accepted before stages agreed.");

    property p_open_drain_low;
        ##1 (pin_out & $past(st.open_drain_select)) == 8'h00;
    endproperty
    a_open_drain_low: assert property (p_open_drain_low)
        else $error("Open-drain pin shows a high value.");

    property p_gpio_drive;
        ##1 (~pin_oe_n & ~$past(st.altsel) & ~$past(st.dir)) == 8'h00;
    endproperty
    a_gpio_drive: assert property (p_gpio_drive)
        else $error("Input pin driven.");

    property p_gpio_value;
        ##1 ((pin_out ^ $past(st.data)) & ~$past(st.altsel) & ~$past(st.open_drain_select)) == 8'h00;
    endproperty
    a_gpio_value: assert property (p_gpio_value)
        else $error("Pin value differs from data register.");

    property p_alt_in_gated;
        ##1 (alt_in & ~$past(st.altsel)) == 8'h00;
    endproperty
    a_alt_in_gated: assert property (p_alt_in_gated)
        else $error("Peripheral sees a pin it does not own.");

endmodule : gpb_port

`default_nettype wire

// ===== testbench/gpb_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module gpb_pad_model (
    // Clock.
    input  wire logic       mclk,
    // Port side of the pads.
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pad_pull_up,
    input  wire logic [7:0] pad_pull_down,
    // Outside circuitry.
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_drive,
    // Resolved pad level.
    output logic      [7:0] pin_in
);
    logic [7:0] float_pat = 8'h55;

    // A floating pad must not settle to a convenient constant.
    always @(posedge mclk) begin
        float_pat <= ~float_pat;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_drive[i])
                pin_in[i] = ext_val[i];
            else if (pad_pull_up[i])
                pin_in[i] = 1'b1;
            else if (pad_pull_down[i])
                pin_in[i] = 1'b0;
            else
                pin_in[i] = float_pat[i];
        end
    end
endmodule : gpb_pad_model

`default_nettype wire

// ===== testbench/gpb_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpb_params.svh"

module gpb_port_bench;
    logic        mclk;
    logic        resetn;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pad_pull_up, pad_pull_down, pad_digital_en;
    logic [7:0]  alt_out, alt_drive, alt_in, ext_val, ext_drive;
    logic        irq, conv_trigger;
    int          miscompares, samples_checked;
    int          cycles = 0;

    gpb_port dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
        .pad_digital_en(pad_digital_en), .alt_out(alt_out), .alt_drive(alt_drive),
        .alt_in(alt_in), .irq(irq), .conv_trigger(conv_trigger));

    gpb_pad_model pads (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .ext_val(ext_val),
        .ext_drive(ext_drive), .pin_in(pin_in));

    always #10 mclk = ~mclk;

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // The run needs well under a thousand cycles; a hang is cut short here.
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg

    task automatic chk_out(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_out

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 chk_reg(what, exp, rdata);
    endtask : rd_chk

    task automatic t_reset();
        chk_out("pull up", 8'h80, pad_pull_up);
        chk_out("pull down", 8'h00, pad_pull_down);
        chk_out("digital en", 8'h80, pad_digital_en);
        chk_out("oe_n", 8'hff, pin_oe_n);
        rd_chk("altsel", `GPB_OFS_ALTSEL, 32'h80);
        rd_chk("commit", `GPB_OFS_COMMIT, 32'h7f);
        rd_chk("lock", `GPB_OFS_LOCK, `GPB_LOCKED_READ);
        rd_chk("ident", `GPB_OFS_IDENT, `GPB_IDENT_VALUE);
        @(posedge mclk);
        #1 chk_reg("rdata idle", 32'h0, rdata);
        rd_chk("unmapped", 12'h600, 32'h0);
        wr_reg(`GPB_OFS_RAW, 32'hff);
        rd_chk("raw ro", `GPB_OFS_RAW, 32'h0);
    endtask : t_reset

    task automatic t_data();
        wr_reg(`GPB_OFS_DIGEN, 32'hff);
        wr_reg(`GPB_OFS_DIR, 32'h7f);
        wr_reg(12'h098, 32'heb);
        wr_reg(12'h004, 32'hff);
        idle(2);
        chk_out("pin out", 8'h23, pin_out & 8'h7f);
        chk_out("oe_n out", 8'h80, pin_oe_n);
        rd_chk("data wide", 12'h1fc, 32'h23);
        rd_chk("data mask", 12'h0c4, 32'h21);
        wr_reg(`GPB_OFS_DIR, 32'h00);
        ext_drive <= 8'h7f;
        ext_val   <= 8'h5a;
        idle(6);
        rd_chk("data in", 12'h1fc, 32'h5a);
    endtask : t_data

    task automatic edge_case(input logic pol, input logic both, input logic v0,
                             input logic v1, input logic fire);
        wr_reg(`GPB_OFS_MASK, 32'h0);
        ext_val[2] <= v0;
        wr_reg(`GPB_OFS_POLARITY, {29'h0, pol, 2'h0});
        wr_reg(`GPB_OFS_BOTH, {29'h0, both, 2'h0});
        idle(6);
        wr_reg(`GPB_OFS_CLEAR, 32'hff);
        wr_reg(`GPB_OFS_MASK, 32'h04);
        ext_val[2] <= v1;
        idle(8);
        chk_out("irq", {7'h0, fire}, {7'h0, irq});
        if (fire) begin
            ext_val[2] <= v0;
            idle(8);
        end
        rd_chk("masked", `GPB_OFS_MASKED, {29'h0, fire, 2'h0});
        wr_reg(`GPB_OFS_CLEAR, 32'h04);
        idle(2);
        chk_out("irq clear", 8'h00, {7'h0, irq});
    endtask : edge_case

    task automatic t_level();
        wr_reg(`GPB_OFS_MASK, 32'h0);
        ext_val[3] <= 1'b0;
        wr_reg(`GPB_OFS_SENSE, 32'h08);
        wr_reg(`GPB_OFS_POLARITY, 32'h08);
        idle(6);
        wr_reg(`GPB_OFS_CLEAR, 32'hff);
        rd_chk("level low", `GPB_OFS_RAW, 32'h0);
        ext_val[3] <= 1'b1;
        idle(6);
        rd_chk("level high", `GPB_OFS_RAW, 32'h08);
        wr_reg(`GPB_OFS_CLEAR, 32'h08);
        rd_chk("level kept", `GPB_OFS_RAW, 32'h08);
        wr_reg(`GPB_OFS_MASK, 32'h08);
        idle(2);
        chk_out("irq level", 8'h01, {7'h0, irq});
        ext_val[3] <= 1'b0;
        idle(6);
        chk_out("irq gone", 8'h00, {7'h0, irq});
        wr_reg(`GPB_OFS_MASK, 32'h0);
        wr_reg(`GPB_OFS_SENSE, 32'h0);
    endtask : t_level

    task automatic t_trigger();
        wr_reg(`GPB_OFS_POLARITY, 32'h10);
        ext_val[4] <= 1'b0;
        idle(6);
        wr_reg(`GPB_OFS_CLEAR, 32'hff);
        ext_val[4] <= 1'b1;
        idle(8);
        rd_chk("raw pin4", `GPB_OFS_RAW, 32'h10);
        chk_out("irq masked", 8'h00, {7'h0, irq});
        chk_out("trig masked", 8'h00, {7'h0, conv_trigger});
        wr_reg(`GPB_OFS_MASK, 32'h10);
        idle(2);
        chk_out("trig", 8'h01, {7'h0, conv_trigger});
        chk_out("irq pin4", 8'h01, {7'h0, irq});
        wr_reg(`GPB_OFS_CLEAR, 32'h10);
        idle(2);
        chk_out("trig clear", 8'h00, {7'h0, conv_trigger});
        wr_reg(`GPB_OFS_MASK, 32'h0);
    endtask : t_trigger

    task automatic t_commit();
        wr_reg(`GPB_OFS_ALTSEL, 32'h01);
        rd_chk("altsel locked", `GPB_OFS_ALTSEL, 32'h81);
        wr_reg(`GPB_OFS_COMMIT, 32'hff);
        rd_chk("commit locked", `GPB_OFS_COMMIT, 32'h7f);
        wr_reg(`GPB_OFS_LOCK, `GPB_LOCK_KEY);
        rd_chk("unlocked", `GPB_OFS_LOCK, 32'h0);
        wr_reg(`GPB_OFS_COMMIT, 32'h80);
        wr_reg(`GPB_OFS_ALTSEL, 32'h01);
        rd_chk("altsel open", `GPB_OFS_ALTSEL, 32'h01);
        wr_reg(`GPB_OFS_LOCK, 32'h0);
        rd_chk("relocked", `GPB_OFS_LOCK, `GPB_LOCKED_READ);
        ext_drive <= 8'h7e;
        alt_out   <= 8'h01;
        alt_drive <= 8'h01;
        idle(8);
        chk_out("alt oe_n", 8'h00, {7'h0, pin_oe_n[0]});
        chk_out("alt out", 8'h01, {7'h0, pin_out[0]});
        chk_out("alt in", 8'h01, {7'h0, alt_in[0]});
    endtask : t_commit

    task automatic t_pads();
        wr_reg(`GPB_OFS_OPENDRAIN, 32'h02);
        wr_reg(`GPB_OFS_PULLUP, 32'h08);
        wr_reg(`GPB_OFS_PULLDOWN, 32'h04);
        wr_reg(`GPB_OFS_DIR, 32'h02);
        wr_reg(12'h008, 32'h02);
        idle(2);
        chk_out("pull up set", 8'h08, pad_pull_up);
        chk_out("pull down set", 8'h04, pad_pull_down);
        chk_out("od high oe_n", 8'h01, {7'h0, pin_oe_n[1]});
        chk_out("od out", 8'h00, {7'h0, pin_out[1]});
        wr_reg(12'h008, 32'h00);
        idle(2);
        chk_out("od low oe_n", 8'h00, {7'h0, pin_oe_n[1]});
        wr_reg(`GPB_OFS_DIGEN, 32'hfd);
        idle(2);
        chk_out("no den oe_n", 8'h01, {7'h0, pin_oe_n[1]});
    endtask : t_pads

    initial begin
        mclk            = 1'b0;
        resetn          = 1'b0;
        addr            = 12'h0;
        wdata           = 32'h0;
        wr              = 1'b0;
        rd              = 1'b0;
        alt_out         = 8'h0;
        alt_drive       = 8'h0;
        ext_val         = 8'h0;
        ext_drive       = 8'h0;
        miscompares     = 0;
        samples_checked = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_data();
        edge_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        edge_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        edge_case(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        edge_case(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        edge_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        edge_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        t_level();
        t_trigger();
        t_commit();
        t_pads();
        report_and_stop();
    end
endmodule : gpb_port_bench

`default_nettype wire
